/* verilog/pgd_consts.vh */
`ifndef PGD_CONSTS_VH
`define PGD_CONSTS_VH
// register addresses
`define PGD_ADDR_CTRL 8'h71
`define PGD_ADDR_STAT 8'h72
`define PGD_ADDR_FLAGS 8'h73
// control register fields
`define PGD_SEL_LO 0
`define PGD_SEL_HI 1
`define PGD_GEN_INV_BIT 2
`define PGD_DET_INV_BIT 3
// status / irq enable register fields
`define PGD_LOCK_IRQ_EN_BIT 0
`define PGD_LOCKED_BIT 1
`define PGD_ERR_INSERT_BIT 2
`define PGD_BERR_IRQ_EN_BIT 3
// flag register fields
`define PGD_LOCK_FLAG_BIT 0
`define PGD_BERR_FLAG_BIT 3
// pattern select codes
`define PGD_SEL_15 2'h0
`define PGD_SEL_20 2'h1
`define PGD_SEL_11 2'h2
// lock criteria
`define PGD_WINDOW_BITS 6'h30
`define PGD_LOSS_ERRORS 6'h0a
`endif

/* verilog/pgd_lfsr.v */
`timescale 1ns/10ps
`include "pgd_consts.vh"
// one step of the selectable pattern register (x^15+x^14, x^20+x^3, x^11+x^9)
module pgd_lfsr (
    input wire [1:0] sel,
    input wire [19:0] state,
    output reg fb
);
    // feedback tap pair per sequence length
    always @* begin
        if (sel == `PGD_SEL_20) begin
            fb = state[19] ^ state[2];
        end else if (sel == `PGD_SEL_11) begin
            fb = state[10] ^ state[8];
        end else begin
            // reserved code falls back to the 15-bit sequence
            fb = state[14] ^ state[13];
        end
    end
endmodule

/* verilog/pgd_window.v */
`timescale 1ns/10ps
`include "pgd_consts.vh"
// lock supervisor: fixed window error count and error-free run count
module pgd_window (
    input wire clk,
    input wire rst_n,
    input wire step,
    input wire err,
    output reg locked
);
    reg [5:0] win_pos; // position in the fixed window
    reg [5:0] win_errs; // errors seen in current window
    reg [5:0] clean_run; // consecutive error-free bits
    wire [5:0] errs_now = win_errs + {5'h00, err};
    // window and run counters and the lock state
    always @(posedge clk) begin
        if (!rst_n) begin
            win_pos <= 6'h00;
            win_errs <= 6'h00;
            clean_run <= 6'h00;
            locked <= 1'b0;
        end else if (step) begin
            // run of clean bits, saturating at the window size
            if (err) begin
                clean_run <= 6'h00;
            end else if (clean_run != `PGD_WINDOW_BITS) begin
                clean_run <= clean_run + 6'h01;
            end
            if (!locked) begin
                // acquiring: one full window of clean bits
                if (!err && clean_run == `PGD_WINDOW_BITS - 6'h01) begin
                    locked <= 1'b1; // see R6
                    win_pos <= 6'h00;
                    win_errs <= 6'h00;
                end
            end else if (errs_now >= `PGD_LOSS_ERRORS) begin
                // too many errors inside the current window
                locked <= 1'b0; // see R5
                win_pos <= 6'h00;
                win_errs <= 6'h00;
            end else if (win_pos == `PGD_WINDOW_BITS - 6'h01) begin
                // window closed, start a fresh one
                win_pos <= 6'h00;
                win_errs <= 6'h00;
            end else begin
                win_pos <= win_pos + 6'h01;
                win_errs <= errs_now;
            end
        end
    end
endmodule

/* verilog/pgd_prbs_gen_detect.v */
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "pgd_consts.vh"
// How it works
// R1 - select picks 15, 20 or 11-bit sequence
// R2 - generator invert complements transmitted pattern
// R3 - detector invert complements received data
// R4 - insert flips one bit, then self-clears
// R5 - ten errors in 48-bit window unlocks
// R6 - 48 clean bits in a row locks
// R7 - lock change flag on every toggle
// R8 - bit error flag on mismatch while locked
// R9 - flags cleared only by writing one
// R10 - bit error flag and enable drive irq
// R11 - lock change flag and enable drive irq
// R12 - one bit per enable; reseed when unlocked
module pgd_prbs_gen_detect (
    input wire clk,
    input wire rst_n,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire tx_bit_en,
    output reg tx_data,
    input wire rx_bit_en,
    input wire rx_data,
    output wire int_n
);
    // control bits
    reg [1:0] pattern_select;
    reg generator_invert;
    reg detector_invert;
    reg bit_error_irq_enable;
    reg lock_change_irq_enable;
    reg single_error_insert;
    // sticky flags
    reg bit_error_flag;
    reg lock_change_flag;
    // pattern registers
    reg [19:0] gen_state;
    reg [19:0] det_state;
    reg locked_q; // lock state one cycle ago
    // synchronised stream inputs
    reg tx_en_s1, tx_en_s2, rx_en_s1, rx_en_s2, rx_d_s1, rx_d_s2;
    wire gen_fb;
    wire det_fb;
    wire pattern_locked;
    wire det_bit; // received bit after optional inversion
    wire mismatch;
    wire wr_ctrl = wr && addr == `PGD_ADDR_CTRL;
    wire wr_stat = wr && addr == `PGD_ADDR_STAT;
    wire wr_flags = wr && addr == `PGD_ADDR_FLAGS;
    wire lock_toggle = pattern_locked != locked_q;
    wire berr_event = rx_en_s2 && mismatch && pattern_locked;

    // pattern register bits that take part in the selected length
    function [19:0] pgd_len_mask;
        input [1:0] sel;
        begin
            if (sel == `PGD_SEL_20) begin
                pgd_len_mask = 20'hfffff; // full 20-bit register
            end else if (sel == `PGD_SEL_11) begin
                pgd_len_mask = 20'h007ff; // low 11 bits only
            end else begin
                pgd_len_mask = 20'h07fff; // low 15 bits, reserved code too
            end
        end
    endfunction

    // nonzero seed so the active part never sticks at all zeros;
    // a switch to a shorter length can leave only zeros in the taps
    function [19:0] pgd_seed_fix;
        input [1:0] sel;
        input [19:0] s;
        begin
            if ((s & pgd_len_mask(sel)) == 20'h00000) begin
                // force a one into the newest bit
                pgd_seed_fix = s | 20'h00001;
            end else begin
                // pattern still alive, keep it
                pgd_seed_fix = s;
            end
        end
    endfunction

    // generator feedback
    pgd_lfsr u_gen_lfsr (
        .sel(pattern_select),
        .state(gen_state),
        .fb(gen_fb)
    );
    // expected-bit feedback for the checker
    pgd_lfsr u_det_lfsr (
        .sel(pattern_select),
        .state(det_state),
        .fb(det_fb)
    );
    // lock supervision over the checked bit stream
    pgd_window u_window (
        .clk(clk),
        .rst_n(rst_n),
        .step(rx_en_s2),
        .err(mismatch),
        .locked(pattern_locked)
    );

    assign det_bit = rx_d_s2 ^ detector_invert; // see R3
    assign mismatch = det_bit != det_fb;
    assign int_n = !((bit_error_flag && bit_error_irq_enable) || // see R10
        (lock_change_flag && lock_change_irq_enable)); // see R11

    // two-stage synchronisers for the bit stream pins
    always @(posedge clk) begin
        if (!rst_n) begin
            tx_en_s1 <= 1'b0;
            tx_en_s2 <= 1'b0;
            rx_en_s1 <= 1'b0;
            rx_en_s2 <= 1'b0;
            rx_d_s1 <= 1'b0;
            rx_d_s2 <= 1'b0;
        end else begin
            tx_en_s1 <= tx_bit_en;
            tx_en_s2 <= tx_en_s1;
            rx_en_s1 <= rx_bit_en;
            rx_en_s2 <= rx_en_s1;
            rx_d_s1 <= rx_data;
            rx_d_s2 <= rx_d_s1;
        end
    end

    // control registers and the self-clearing error insert
    always @(posedge clk) begin
        if (!rst_n) begin
            pattern_select <= `PGD_SEL_15;
            generator_invert <= 1'b0;
            detector_invert <= 1'b0;
            bit_error_irq_enable <= 1'b0;
            lock_change_irq_enable <= 1'b0;
            single_error_insert <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                pattern_select <= wdata[`PGD_SEL_HI:`PGD_SEL_LO]; // see R1
                generator_invert <= wdata[`PGD_GEN_INV_BIT];
                detector_invert <= wdata[`PGD_DET_INV_BIT];
            end
            if (wr_stat) begin
                bit_error_irq_enable <= wdata[`PGD_BERR_IRQ_EN_BIT];
                lock_change_irq_enable <= wdata[`PGD_LOCK_IRQ_EN_BIT];
            end
            // a pending insert is consumed by the next transmitted bit
            if (wr_stat && wdata[`PGD_ERR_INSERT_BIT]) begin
                single_error_insert <= 1'b1;
            end else if (tx_en_s2) begin
                single_error_insert <= 1'b0; // see R4
            end
        end
    end

    // generator: one bit per transmit enable
    always @(posedge clk) begin
        if (!rst_n) begin
            gen_state <= 20'h00001;
            tx_data <= 1'b0;
        end else if (tx_en_s2) begin
            gen_state <= pgd_seed_fix(pattern_select, {gen_state[18:0], gen_fb}); // see R12
            // optional inversion and one-shot error
            tx_data <= gen_fb ^ generator_invert ^ single_error_insert; // see R2 see R4
        end
    end

    // checker: self-run when locked, reseed from received bits otherwise
    always @(posedge clk) begin
        if (!rst_n) begin
            det_state <= 20'h00001;
        end else if (rx_en_s2) begin
            if (pattern_locked) begin
                det_state <= pgd_seed_fix(pattern_select, {det_state[18:0], det_fb});
            end else begin
                det_state <= {det_state[18:0], det_bit}; // see R12
            end
        end
    end

    // sticky flags; a new event wins over a clear in the same cycle
    always @(posedge clk) begin
        if (!rst_n) begin
            locked_q <= 1'b0;
            bit_error_flag <= 1'b0;
            lock_change_flag <= 1'b0;
        end else begin
            locked_q <= pattern_locked;
            if (berr_event) begin
                bit_error_flag <= 1'b1; // see R8
            end else if (wr_flags && wdata[`PGD_BERR_FLAG_BIT]) begin
                bit_error_flag <= 1'b0; // see R9
            end
            if (lock_toggle) begin
                lock_change_flag <= 1'b1; // see R7
            end else if (wr_flags && wdata[`PGD_LOCK_FLAG_BIT]) begin
                lock_change_flag <= 1'b0; // see R9
            end
        end
    end

    // read data, one cycle after the read strobe
    always @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (addr == `PGD_ADDR_CTRL) begin
                rdata <= {4'h0, detector_invert, generator_invert, pattern_select};
            end else if (addr == `PGD_ADDR_STAT) begin
                rdata <= {4'h0, bit_error_irq_enable, single_error_insert,
                    pattern_locked, lock_change_irq_enable};
            end else if (addr == `PGD_ADDR_FLAGS) begin
                rdata <= {4'h0, bit_error_flag, 2'h0, lock_change_flag};
            end else begin
                rdata <= 8'h00; // unmapped address
            end
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule

/* dv/pgd_asserts.sv */
`timescale 1ns/10ps
// port checks on the pattern block
module pgd_asserts (
    input wire clk,
    input wire rst_n,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire tx_bit_en,
    input wire tx_data,
    input wire int_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data without a read");
    a_unmapped_zero: assert property ($past(rd) && ($past(addr) < 8'h71 ||
        $past(addr) > 8'h73) |-> rdata == 8'h00) else $error("unmapped read not zero");
    a_upper_zero: assert property (rdata[7:4] == 4'h0)
        else $error("upper read bits set");
    a_flags_rsvd: assert property ($past(rd) && $past(addr) == 8'h73 |->
        rdata[2:1] == 2'h0) else $error("reserved flag bits set");
    a_ctrl_back: assert property (wr && addr == 8'h71 ##1 rd && addr == 8'h71 |=>
        rdata == ($past(wdata, 2) & 8'h0f)) else $error("control readback wrong");
    a_tx_steps: assert property ($changed(tx_data) |->
        $past(tx_bit_en, 2) || $past(tx_bit_en, 3)) else $error("pattern moved without step");
    a_int_release: assert property ($rose(int_n) |-> $past(wr))
        else $error("interrupt dropped by itself");
    a_lock_clear: assert property (wr && addr == 8'h73 && wdata[0] ##1
        rd && addr == 8'h73 |=> !rdata[0]) else $error("lock flag not cleared");
endmodule
bind pgd_prbs_gen_detect pgd_asserts u_chk (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_bit_en(tx_bit_en),
    .tx_data(tx_data), .int_n(int_n));

/* dv/pgd_framer_model.sv */
`timescale 1ns/10ps
// far side: framer bit timing, receive stream looped from transmit
module pgd_framer_model (
    input wire clk,
    input wire rst_n,
    input wire tx_data,
    output reg tx_bit_en = 1'b0,
    output reg rx_bit_en = 1'b0,
    output reg rx_data = 1'b0
);
    reg [2:0] phase = 3'h0; // one bit every eight clocks
    // bit enables in both directions; received bit is last sent bit
    always @(posedge clk) begin
        phase <= rst_n ? phase + 3'h1 : 3'h0;
        tx_bit_en <= (phase == 3'h0);
        rx_bit_en <= (phase == 3'h0);
        rx_data <= tx_data;
    end
endmodule

/* dv/testbench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    reg clk = 0, rst_n = 0, wr = 0, rd = 0;
    reg [7:0] addr = 0, wdata = 0;
    wire [7:0] rdata;
    wire tx_data, tx_bit_en, rx_bit_en, rx_data, int_n;
    integer miscompares = 0, comparisons = 0, i;
    reg [7:0] ctl [0:3];
    always #12.5 clk = ~clk;
    pgd_prbs_gen_detect DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .tx_bit_en(tx_bit_en), .tx_data(tx_data),
        .rx_bit_en(rx_bit_en), .rx_data(rx_data), .int_n(int_n));
    pgd_framer_model FRM (.clk(clk), .rst_n(rst_n), .tx_data(tx_data),
        .tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en), .rx_data(rx_data));
    // one write cycle
    task wreg(input [7:0] a, input [7:0] d); begin
        addr <= a; wdata <= d; wr <= 1; @(posedge clk); wr <= 0; #1;
    end endtask
    // one read cycle, data compared in the following cycle
    task rchk(input [7:0] a, input [7:0] e); begin
        addr <= a; rd <= 1; @(posedge clk); rd <= 0; #1 `CHK(rdata, e)
    end endtask
    // wait a number of pattern bits
    task bits(input integer n); begin
        repeat (n * 8) @(posedge clk); #1;
    end endtask
    task tally_and_finish; begin
        if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    end endtask
    initial begin
        #2000000 miscompares++;
        tally_and_finish;
    end
    initial begin
        ctl[0] = 8'h06; ctl[1] = 8'h0e; ctl[2] = 8'h0a; ctl[3] = 8'h02;
        repeat (20) @(posedge clk);
        rst_n <= 1; #1;
        rchk(8'h71, 0); rchk(8'h72, 0); rchk(8'h73, 0); rchk(8'h74, 0);
        wreg(8'h71, 8'h0e); rchk(8'h71, 8'h0e);
        wreg(8'h70, 8'hff); rchk(8'h71, 8'h0e);
        wreg(8'h72, 8'h0b); rchk(8'h72, 8'h09);
        // each pattern length locks over the loopback
        for (i = 0; i < 3; i++) begin
            wreg(8'h72, 0); wreg(8'h71, i); bits(200); wreg(8'h73, 8'h09);
            rchk(8'h72, 8'h02); rchk(8'h73, 0);
        end
        // each invert flip alternately breaks lock and lets it reacquire
        for (i = 0; i < 4; i++) begin
            wreg(8'h72, 8'h09); wreg(8'h71, ctl[i]); bits(150);
            if (i % 2 == 0) begin
                rchk(8'h72, 8'h09); `CHK(int_n, 1'b0)
                rchk(8'h73, 8'h09);
                wreg(8'h73, 0); rchk(8'h73, 8'h09);
                wreg(8'h73, 8'h01); rchk(8'h73, 8'h08); `CHK(int_n, 1'b0)
                wreg(8'h72, 8'h01); `CHK(int_n, 1'b1)
                wreg(8'h73, 8'h08); rchk(8'h73, 0);
            end else begin
                rchk(8'h72, 8'h0b); rchk(8'h73, 8'h01); `CHK(int_n, 1'b0)
                wreg(8'h72, 8'h08); `CHK(int_n, 1'b1)
                wreg(8'h73, 8'h09); rchk(8'h73, 0);
            end
        end
        // one inserted error is seen while lock holds
        wreg(8'h72, 8'h0c); bits(4); rchk(8'h72, 8'h0a);
        rchk(8'h73, 8'h08); `CHK(int_n, 1'b0)
        tally_and_finish;
    end
endmodule
